// ### step_queue_trigger_sequencer.sv
// step queue command interpreter with Avalon-MM register slave.
// assumes trigger inputs synchronous to clk_i; interrupt and trigger outputs are one-cycle pulses.
`default_nettype none
module step_queue_trigger_sequencer
  import step_queue_pkg::*;
#(
  parameter int NUM_TRIG_IN = 16,
  parameter int NUM_IRQ = 16,
  parameter int NUM_TRIG_OUT = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // peripheral side
  input wire logic [NUM_TRIG_IN-1:0] trig_in_i,
  output logic [NUM_IRQ-1:0] irq_o,
  output logic [NUM_TRIG_OUT-1:0] trig_out_o,
  output logic [15:0] adc_chan_sel_o
);
  // option fields and 5-bit targets index these directly
  if (NUM_TRIG_IN < 16 || NUM_IRQ < 16 || NUM_TRIG_OUT < 32)
  begin : g_bad_param
    $error("trigger or interrupt width too small for option field");
  end

  logic rst_meta_q;
  logic rst_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q <= rst_meta_q;
    end
  end

  // bus slave: one wait cycle, answer in the cycle after the request
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_val;
  wire req = read_i | write_i;
  wire wr_acc = write_i & ~wait_q;
  wire [15:0] wmask = {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [15:0] m);
    merge16 = (old & ~m) | (wd[15:0] & m);
  endfunction

  logic [2:0] ctrl_q;
  logic [4:0] ptr_q, ptr_d;
  logic [15:0] adj_q, adj_d, hold_q, hold_d;
  logic [NUM_LIM-1:0][15:0] lim_q, lim_d;
  logic [15:0] cnt_a_q, cnt_a_d, cnt_b_q, cnt_b_d;
  logic [15:0] adc_q, adc_d;
  logic [15:0] tmr_q, tmr_d, dly_q, dly_d;
  logic sd_en_q, sd_en_d;
  logic swt_prev_q;
  logic [NUM_TRIG_IN-1:0] trig_prev_q;
  logic [NUM_IRQ-1:0] irq_q, irq_d;
  logic [NUM_TRIG_OUT-1:0] trig_q, trig_d;
  eng_e state_q, state_d;
  logic [15:0] queue_q [NUM_PAIRS];

  wire exec = ctrl_q[CTRL_EN] & ctrl_q[CTRL_START];
  wire hit_ctrl = address_i == OFF_CTRL;
  wire hit_qptr = address_i == OFF_QPTR;
  wire hit_adj = address_i == OFF_ADJ;
  wire hit_hold = address_i == OFF_HOLD;
  // the queue window is 0x40..0x5C only; the space above it reads zero
  wire hit_queue = address_i[6:5] == OFF_QUEUE_BASE[6:5];
  wire [15:0] qptr_merged = merge16({11'h000, ptr_q}, writedata_i, wmask);

  // step queue: no reset at all, contents survive every reset
  // pair register byte layout
  for (genvar i = 0; i < NUM_PAIRS; i++)
  begin : g_queue
    wire q_we = wr_acc & ~exec & (address_i == OFF_QUEUE_BASE + 7'(4 * i));
    always_ff @(posedge clk_i)
    begin
      if (q_we)
        queue_q[i] <= merge16(queue_q[i], writedata_i, wmask);
    end
  end

  // step fetch and decode
  // opcode and option split
  wire [15:0] pair = queue_q[ptr_q[3:1]];
  wire step_s cur = ptr_q[0] ? pair[15:8] : pair[7:0];
  wire [4:0] target = {cur.op[0], cur.opt};
  wire [NUM_TRIG_IN-1:0] rise = trig_in_i & ~trig_prev_q;
  wire [NUM_TRIG_IN-1:0] fall = ~trig_in_i & trig_prev_q;
  wire sw_rise = ctrl_q[CTRL_SWT] & ~swt_prev_q;
  wire is_ctrl = cur.op == OP_CTRL;
  wire is_jump = cur.op[3:1] == OPP_JUMP;
  wire is_jump_a = cur.op[3:1] == OPP_JUMP_A;
  wire is_jump_b = cur.op[3:1] == OPP_JUMP_B;
  wire at_lim_a = cnt_a_q == lim_q[LIM_CA];
  wire at_lim_b = cnt_b_q == lim_q[LIM_CB];
  wire [2:0] lim_idx = cur.opt[2:0];
  wire lim_ok = lim_idx <= LIM_LIT;

  logic cond;
  always_comb
  begin
    cond = 1'b1;
    if (cur.op == OP_WAIT_RISE)
      cond = rise[cur.opt];
    else if (cur.op == OP_WAIT_FALL)
      cond = fall[cur.opt];
    else if (is_ctrl && cur.opt == CO_SWT)
      cond = sw_rise;
    else if (is_ctrl && cur.opt == CO_TMR0)
      cond = tmr_q == lim_q[LIM_T0];
    else if (is_ctrl && cur.opt == CO_TMR1)
      cond = tmr_q == lim_q[LIM_T1];
  end
  // a stopped engine finishes no step, even in its last EXEC cycle
  wire done = (state_q == ST_EXEC) & exec & cond;

  always_comb
  begin
    state_d = state_q;
    ptr_d = ptr_q;
    adj_d = adj_q;
    hold_d = hold_q;
    lim_d = lim_q;
    cnt_a_d = cnt_a_q;
    cnt_b_d = cnt_b_q;
    adc_d = adc_q;
    tmr_d = tmr_q;
    dly_d = dly_q;
    sd_en_d = sd_en_q;
    irq_d = '0;
    trig_d = '0;
    // software writes other than to control only while the engine is stopped
    // limit, literal and queue loads need a stopped engine
    if (wr_acc && !exec)
    begin
      if (hit_qptr)
        ptr_d = qptr_merged[4:0];
      if (hit_adj)
        adj_d = merge16(adj_q, writedata_i, wmask);
      if (hit_hold)
        hold_d = merge16(hold_q, writedata_i, wmask);
      for (int k = 0; k < NUM_LIM; k++)
      begin
        if (address_i == OFF_LIM_BASE + 7'(4 * k))
          lim_d[k] = merge16(lim_q[k], writedata_i, wmask);
      end
    end
    case (state_q)
      ST_IDLE:
      begin
        if (exec)
          state_d = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (!done)
          tmr_d = tmr_q + 16'h0001;
        else
        begin
          tmr_d = RST_REG16;
          ptr_d = ptr_q + 5'h01;
          // anything not matched below changes nothing
          if (is_ctrl)
          begin
            if (cur.opt == CO_SD_OFF)
              sd_en_d = 1'b0;
            if (cur.opt == CO_SD_ON)
              sd_en_d = 1'b1;
            if (cur.opt == CO_CNT_A)
              adc_d = cnt_a_q;
            if (cur.opt == CO_CNT_B)
              adc_d = cnt_b_q;
            if (cur.opt == CO_LIT)
              adc_d = lim_q[LIM_LIT];
          end
          // option picks limit or literal slot
          if (cur.op == OP_ADDCOPY && lim_ok)
          begin
            if (!cur.opt[3])
              lim_d[lim_idx] = lim_q[lim_idx] + adj_q;
            else
              lim_d[lim_idx] = hold_q;
          end
          if (cur.op[3:1] == OPP_STROBE)
            adc_d[4:0] = target;
          if (cur.op == OP_IRQ)
            irq_d[cur.opt] = 1'b1;
          if (cur.op[3:1] == OPP_TRIG)
            trig_d[target] = 1'b1;
          if (is_jump)
            ptr_d = target;
          if (is_jump_a && !at_lim_a)
          begin
            cnt_a_d = cnt_a_q + 16'h0001;
            ptr_d = target;
          end
          if (is_jump_b && !at_lim_b)
          begin
            cnt_b_d = cnt_b_q + 16'h0001;
            ptr_d = target;
          end
          // extra delay cycles before next step
          if (sd_en_q && lim_q[LIM_SD] != RST_REG16)
          begin
            dly_d = lim_q[LIM_SD];
            state_d = ST_DELAY;
          end
        end
      end
      ST_DELAY:
      begin
        dly_d = dly_q - 16'h0001;
        if (dly_q == 16'h0001)
          state_d = ST_EXEC;
      end
      default:
        state_d = ST_IDLE;
    endcase
    // disabling the engine resets the loop counters; stopping parks it
    if (!ctrl_q[CTRL_EN])
    begin
      cnt_a_d = RST_REG16;
      cnt_b_d = RST_REG16;
    end
    if (!exec)
    begin
      state_d = ST_IDLE;
      tmr_d = RST_REG16;
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (hit_ctrl)
      rd_val[2:0] = ctrl_q;
    else if (address_i == OFF_STATUS)
      rd_val[2:0] = {sd_en_q, state_q == ST_DELAY, exec};
    // pointer in low five bits, rest zero
    else if (hit_qptr)
      rd_val[4:0] = ptr_q;
    else if (hit_adj)
      rd_val[15:0] = adj_q;
    else if (hit_hold)
      rd_val[15:0] = hold_q;
    else if (address_i == OFF_CNT_A)
      rd_val[15:0] = cnt_a_q;
    else if (address_i == OFF_CNT_B)
      rd_val[15:0] = cnt_b_q;
    else if (address_i == OFF_ADC)
      rd_val[15:0] = adc_q;
    else if (address_i >= OFF_LIM_BASE && address_i < OFF_HOLD && address_i[1:0] == 2'h0)
      rd_val[15:0] = lim_q[3'(address_i[4:2] - 3'h4)];
    else if (hit_queue && address_i[1:0] == 2'h0)
      rd_val[15:0] = queue_q[address_i[4:2]];
  end

  always_ff @(posedge clk_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= 3'h0;
    end
    else
    begin
      wait_q <= ~(req & wait_q);
      if (read_i && wait_q)
        rdata_q <= rd_val;
      if (wr_acc && hit_ctrl && byteenable_i[0])
        ctrl_q <= writedata_i[2:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_q)
  begin
    if (!rst_q)
    begin
      state_q <= ST_IDLE;
      ptr_q <= RST_QPTR;
      adj_q <= RST_REG16;
      hold_q <= RST_REG16;
      lim_q <= '0;
      cnt_a_q <= RST_REG16;
      cnt_b_q <= RST_REG16;
      adc_q <= RST_REG16;
      tmr_q <= RST_REG16;
      dly_q <= RST_REG16;
      sd_en_q <= 1'b0;
      swt_prev_q <= 1'b0;
      trig_prev_q <= '0;
      irq_q <= '0;
      trig_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      adj_q <= adj_d;
      hold_q <= hold_d;
      lim_q <= lim_d;
      cnt_a_q <= cnt_a_d;
      cnt_b_q <= cnt_b_d;
      adc_q <= adc_d;
      tmr_q <= tmr_d;
      dly_q <= dly_d;
      sd_en_q <= sd_en_d;
      swt_prev_q <= ctrl_q[CTRL_SWT];
      trig_prev_q <= trig_in_i;
      irq_q <= irq_d;
      trig_q <= trig_d;
    end
  end

  assign readdata_o = rdata_q;
  assign waitrequest_o = wait_q;
  assign irq_o = irq_q;
  assign trig_out_o = trig_q;
  assign adc_chan_sel_o = adc_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_q);

  a_ptr_locked: assert property (exec && !done |=> ptr_q == $past(ptr_q))
    else $error("pointer moved without a finished step");
  a_ptr_advance: assert property (done && !is_jump && !is_jump_a && !is_jump_b
    |=> ptr_q == 5'($past(ptr_q) + 5'h01))
    else $error("pointer did not advance by one");
  a_jump_load: assert property (done && is_jump |=> ptr_q == $past(target))
    else $error("jump did not load target");
  a_rise_stall: assert property (exec && state_q == ST_EXEC && cur.op == OP_WAIT_RISE
    && !rise[cur.opt] |=> ptr_q == $past(ptr_q) && state_q == ST_EXEC)
    else $error("rise wait did not stall");
  a_fall_stall: assert property (state_q == ST_EXEC && cur.op == OP_WAIT_FALL
    && !fall[cur.opt] |=> ptr_q == $past(ptr_q) && irq_o == '0)
    else $error("fall wait did not stall");
  a_strobe_chan: assert property (done && cur.op[3:1] == OPP_STROBE
    |=> adc_chan_sel_o[4:0] == $past(target) && adc_chan_sel_o[15:5] == $past(adc_q[15:5]))
    else $error("channel strobe value wrong");
  a_irq_pulse: assert property (done && cur.op == OP_IRQ
    |=> irq_o[$past(cur.opt)] ##1 (irq_o == '0 || $past(done)))
    else $error("interrupt pulse wrong");
  a_trig_pulse: assert property (done && cur.op[3:1] == OPP_TRIG
    |=> trig_out_o[$past(target)] && $onehot(trig_out_o))
    else $error("trigger pulse wrong");
  a_loop_a: assert property (done && is_jump_a && !at_lim_a
    |=> cnt_a_q == 16'($past(cnt_a_q) + 16'h0001) && ptr_q == $past(target))
    else $error("counted jump a wrong");
  a_loop_b_exit: assert property (done && is_jump_b && at_lim_b
    |=> cnt_b_q == $past(cnt_b_q) && ptr_q == 5'($past(ptr_q) + 5'h01))
    else $error("counted jump b exit wrong");
  a_delay_gap: assert property (done && sd_en_q && exec && ctrl_q[CTRL_EN]
    && lim_q[LIM_SD] == 16'h0002 ##1 exec[*2] |-> !done && $past(!done))
    else $error("step delay too short");
endmodule
`default_nettype wire

// ### step_queue_pkg.sv
// step queue sequencer constants: register map, field layout, opcodes, resets.
// assumes a 32-bit Avalon-MM slave port with byte addresses, one register per word.
// What this block does
// - literal register, reset zero, copied to channel select
// - five-bit queue pointer, upper bits read zero
// - pointer writes ignored while engine executes
// - eight pair registers hold sixteen step bytes
// - step queue never cleared by reset
// - opcode high nibble, option low; control steps
// - add step adds adjust into target
// - copy step copies hold into target
// - channel strobe writes five-bit value low bits
// - wait for rising edge on input
// - wait for falling edge on input
// - reserved opcodes and options act as nops
// - interrupt step pulses selected interrupt request
// - trigger step pulses selected trigger output
// - jump step loads pointer, continues there
// - counted jump a: loop counter a
// - counted jump b: loop counter b
// - add/copy option targets limits and literal
// - step takes one clock plus delay limit
// - control wait until software trigger rises
`default_nettype none
package step_queue_pkg;
  localparam int ADDR_W = 7;
  localparam logic [6:0] OFF_CTRL = 7'h00;
  localparam logic [6:0] OFF_STATUS = 7'h04;
  localparam logic [6:0] OFF_QPTR = 7'h08;
  localparam logic [6:0] OFF_ADJ = 7'h0C;
  localparam logic [6:0] OFF_LIM_BASE = 7'h10;
  localparam logic [6:0] OFF_HOLD = 7'h28;
  localparam logic [6:0] OFF_CNT_A = 7'h2C;
  localparam logic [6:0] OFF_CNT_B = 7'h30;
  localparam logic [6:0] OFF_ADC = 7'h34;
  localparam logic [6:0] OFF_QUEUE_BASE = 7'h40;
  localparam int NUM_PAIRS = 8;
  // limit slots, in add/copy option order
  localparam int NUM_LIM = 6;
  localparam logic [2:0] LIM_CA = 3'h0;
  localparam logic [2:0] LIM_CB = 3'h1;
  localparam logic [2:0] LIM_T0 = 3'h2;
  localparam logic [2:0] LIM_T1 = 3'h3;
  localparam logic [2:0] LIM_SD = 3'h4;
  localparam logic [2:0] LIM_LIT = 3'h5;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [4:0] RST_QPTR = 5'h00;
  localparam int CTRL_EN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_SWT = 2;
  localparam logic [3:0] OP_CTRL = 4'h0;
  localparam logic [3:0] OP_ADDCOPY = 4'h1;
  localparam logic [3:0] OP_WAIT_RISE = 4'h4;
  localparam logic [3:0] OP_WAIT_FALL = 4'h5;
  localparam logic [3:0] OP_IRQ = 4'h7;
  localparam logic [2:0] OPP_STROBE = 3'h1;
  localparam logic [2:0] OPP_TRIG = 3'h4;
  localparam logic [2:0] OPP_JUMP = 3'h5;
  localparam logic [2:0] OPP_JUMP_A = 3'h6;
  localparam logic [2:0] OPP_JUMP_B = 3'h7;
  localparam logic [3:0] CO_SD_OFF = 4'h2;
  localparam logic [3:0] CO_SD_ON = 4'h6;
  localparam logic [3:0] CO_TMR0 = 4'h8;
  localparam logic [3:0] CO_TMR1 = 4'h9;
  localparam logic [3:0] CO_SWT = 4'hB;
  localparam logic [3:0] CO_CNT_A = 4'hC;
  localparam logic [3:0] CO_CNT_B = 4'hD;
  localparam logic [3:0] CO_LIT = 4'hE;
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] opt;
  } step_s;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DELAY} eng_e;
endpackage
`default_nettype wire

// ### step_queue_periph_model.sv
// peripheral side model: drives trigger inputs, counts interrupt pulses, records which interrupt and trigger bits pulsed.
// assumes the sequencer's pulses are registered on the same clock.
`default_nettype none
module step_queue_periph_model (
  // clock
  input wire logic clk_i,
  // pulses from the sequencer
  input wire logic [15:0] irq_i,
  input wire logic [31:0] trig_i,
  // trigger levels to the sequencer
  output logic [15:0] trig_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int irq_cnt = 0;
  logic [15:0] irq_seen = '0;
  logic [31:0] trig_seen = '0;
  initial trig_in_o = '0;
  // pulses last one cycle, so every edge is sampled
  always @(posedge clk_i)
  begin
    if (irq_i !== '0)
    begin
      irq_cnt++;
      irq_seen |= irq_i;
    end
    if (trig_i !== '0)
      trig_seen |= trig_i;
  end
  task automatic clear();
    irq_seen = '0;
    trig_seen = '0;
  endtask
  // level changes right after an edge, as a synchronous peripheral would
  task automatic drive(input int idx, input logic lvl);
    @(posedge clk_i);
    trig_in_o[idx] <= lvl;
  endtask
endmodule
`default_nettype wire

// ### step_queue_trigger_sequencer_tb.sv
// self-checking bench: register access, three step programs, reset in mid-run.
// assumes the peripheral model on the trigger side and a 50 MHz clock.
`default_nettype none
module step_queue_trigger_sequencer_tb;
  import step_queue_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] A_LIT = 7'h24;
  localparam logic [6:0] A_LIMA = 7'h10;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [6:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = '0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] trig_in;
  logic [15:0] irq;
  logic [31:0] trig_out;
  logic [15:0] chan;
  int fails = 0;
  int num_checks = 0;
  int seed = 75772;
  int base_irq;
  logic [15:0] qmem [8];
  logic [31:0] rd;
  logic [15:0] hold;
  logic [15:0] adj;

  always #10 clk_i = ~clk_i;

  step_queue_trigger_sequencer step_queue_trigger_sequencer_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address), .read_i(read),
    .write_i(write), .writedata_i(writedata), .byteenable_i(4'hF),
    .readdata_o(readdata), .waitrequest_o(waitrequest), .trig_in_i(trig_in),
    .irq_o(irq), .trig_out_o(trig_out), .adc_chan_sel_o(chan));
  step_queue_periph_model step_queue_periph_model_i (
    .clk_i(clk_i), .irq_i(irq), .trig_i(trig_out), .trig_in_o(trig_in));

  task automatic results();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // waitrequest is taken as it stood at each rising edge; the request stays put
  // until the edge that sees it low, and read data is taken at that same edge
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (waitrequest !== 1'b0)
    begin
      fails++;
      results();
    end
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_chan(input logic [15:0] exp);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (chan !== exp && n < 200);
    chk({16'h0, chan}, {16'h0, exp});
    if (chan !== exp)
      results();
  endtask

  // step k of the program sits in bits 8k+7..8k
  task automatic load(input logic [127:0] prog);
    for (int x = 0; x < NUM_PAIRS; x++)
    begin
      qmem[x] = prog[16*x+:16];
      bus(1'b1, 7'(OFF_QUEUE_BASE + 4 * x), {16'h0, qmem[x]});
    end
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  initial
  begin
    hold = 16'($random(seed));
    adj = 16'($random(seed));
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd_chk(A_LIT, 32'h0);
    rd_chk(OFF_QPTR, 32'h0);
    rd_chk(7'h7C, 32'h0);
    bus(1'b1, A_LIT, 32'hABCD_1234);
    rd_chk(A_LIT, 32'h0000_1234);
    // strobe, irq, trigger, wait rise, nop, literal copy, self jump
    load(128'h00A6_0E60_429A_7533);
    rd_chk(7'(OFF_QUEUE_BASE + 4), {16'h0, qmem[1]});
    step_queue_periph_model_i.clear();
    base_irq = step_queue_periph_model_i.irq_cnt;
    bus(1'b1, OFF_CTRL, 32'h3);
    wait_chan(16'h0013);
    // a pointer write now would rerun step 1 and raise a second interrupt
    bus(1'b1, OFF_QPTR, 32'h0);
    repeat (10) @(negedge clk_i);
    chk({16'h0, chan}, 32'h0013);
    chk(32'(step_queue_periph_model_i.irq_cnt - base_irq), 32'h1);
    chk({16'h0, step_queue_periph_model_i.irq_seen}, 32'h0020);
    chk(step_queue_periph_model_i.trig_seen, 32'h0400_0000);
    step_queue_periph_model_i.drive(2, 1'b1);
    wait_chan(16'h1234);
    rd_chk(OFF_QPTR, 32'h6);
    // second program: wait fall, copy, add, literal copy, counted loop
    bus(1'b1, OFF_CTRL, 32'h0);
    bus(1'b1, OFF_QPTR, 32'hFFFF);
    rd_chk(OFF_QPTR, 32'h1F);
    bus(1'b1, OFF_QPTR, 32'h0);
    bus(1'b1, OFF_HOLD, {16'h0, hold});
    bus(1'b1, OFF_ADJ, {16'h0, adj});
    bus(1'b1, A_LIMA, 32'h2);
    load(128'h00A6_C471_0E15_1D52);
    step_queue_periph_model_i.clear();
    base_irq = step_queue_periph_model_i.irq_cnt;
    bus(1'b1, OFF_CTRL, 32'h3);
    repeat (10) @(negedge clk_i);
    chk({16'h0, chan}, 32'h1234);
    step_queue_periph_model_i.drive(2, 1'b0);
    wait_chan(16'(hold + adj));
    repeat (20) @(posedge clk_i);
    // limit 2 gives one pass plus two jumps back
    chk(32'(step_queue_periph_model_i.irq_cnt - base_irq), 32'(2 + 1));
    chk({16'h0, step_queue_periph_model_i.irq_seen}, 32'h0002);
    rd_chk(OFF_QPTR, 32'h6);
    rd_chk(A_LIT, {16'h0, 16'(hold + adj)});
    do_reset();
    chk({16'h0, chan}, 32'h0);
    for (int x = 0; x < NUM_PAIRS; x++)
      rd_chk(7'(OFF_QUEUE_BASE + 4 * x), {16'h0, qmem[x]});
    rd_chk(A_LIT, 32'h0);
    // third program: step delay, counter b loop, software trigger, timer wait
    bus(1'b1, 7'h14, 32'h1);
    bus(1'b1, 7'h18, 32'h5);
    bus(1'b1, 7'h20, 32'h2);
    load(128'hA702_0C08_0BE1_0D06);
    bus(1'b1, OFF_CTRL, 32'h3);
    wait_chan(16'h0001);
    repeat (10) @(negedge clk_i);
    rd_chk(OFF_QPTR, 32'h3);
    rd_chk(OFF_STATUS, 32'h5);
    bus(1'b1, OFF_CTRL, 32'h7);
    wait_chan(16'h0000);
    repeat (10) @(negedge clk_i);
    rd_chk(OFF_QPTR, 32'h7);
    rd_chk(OFF_STATUS, 32'h1);
    rd_chk(OFF_CNT_B, 32'h1);
    results();
  end
endmodule
`default_nettype wire
